// ===== src/mcsr_pkg.sv
package mcsr_pkg;

	localparam int ADDR_W = 10;
	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_SYS_CONFIG = 8'h40;
	localparam logic [7:0] IDX_LIMIT_STATUS = 8'h41;
	localparam logic [ADDR_W-1:0] ADDR_SYS_CONFIG = {IDX_SYS_CONFIG, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_STATUS =
		{IDX_LIMIT_STATUS, 2'b00};
	// own registers: interrupt status/mask and limit values
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 10'h180;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 10'h184;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_BASE = 10'h200;
	// ten limit bytes, one word each
	localparam logic [ADDR_W-1:0] LIMIT_SPAN = 10'h028;
	// limit window: channel in offset bits 3 and up, high/low in bit 2
	localparam int LIM_CH_SHIFT = 3;
	localparam int LIM_HIGH_BIT = 2;
	localparam logic [7:0] CFG_RSVD_MASK = 8'h10;

	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// configuration field positions
	localparam int CFG_GO = 0;
	localparam int CFG_LOCK = 1;
	localparam int CFG_READY = 2;
	localparam int CFG_FANS_MAX = 3;
	localparam int CFG_SPINUP = 5;
	localparam int CFG_TIMEOUT_OFF = 6;
	localparam int CFG_SUPPLY_5V = 7;
	// software-writable bits of the configuration register
	localparam logic [7:0] CFG_WR_MASK = 8'hEB;
	// bits that freeze once the lock is set
	localparam logic [7:0] CFG_LOCKABLE = 8'hC3;

	// status field positions
	localparam int ST_MID_RAIL = 0;
	localparam int ST_SUPPLY = 2;
	localparam int ST_REMOTE_ONE = 4;
	localparam int ST_LOCAL = 5;
	localparam int ST_REMOTE_TWO = 6;
	localparam int ST_SECOND = 7;
	localparam logic [7:0] ST_LATCH_MASK = 8'h75;

	// five monitored channels: mid rail, supply, remote1, local, remote2
	localparam int NUM_CH = 5;
	// limit register index inside the limit window: low at 2n, high at 2n+1
	localparam int NUM_LIM = 10;
	localparam logic [7:0] VOLT_LOW_DEF = 8'h00;
	localparam logic [7:0] VOLT_HIGH_DEF = 8'hFF;
	localparam logic [7:0] TEMP_LOW_DEF = 8'h81;
	localparam logic [7:0] TEMP_HIGH_DEF = 8'h7F;
	// power-up count; ready is raised one cycle after the counter reaches it, 17 cycles after reset release
	localparam int POWERUP_CYCLES = 16;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
	} mcsr_limit_t;

	typedef struct packed {
		logic aw_seen;
		logic [ADDR_W-1:0] aw_addr;
		logic w_seen;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] cfg;
		logic [7:0] status;
		logic [7:0] irq_status;
		logic [7:0] irq_mask;
		logic [4:0] pwr_cnt;
		mcsr_limit_t [NUM_CH-1:0] lim;
	} mcsr_state_t;

endpackage : mcsr_pkg

// ===== src/mcsr_regs.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
// Overview of operation
// - go=1 uses programmed limits; go=0 uses power-up default limits
// - clearing go keeps programmed limit values stored
// - once lock is written, the go bit ignores writes
// - lock writable once; lockable bits frozen until power cycle
// - ready bit set once power-up completes
// - fans_max_override forces full fans, resets 0, never locked
// - spinup_fixed_time holds pwm high for whole spin-up timeout
// - bus_timeout_off disables bus timeout detection; lockable
// - supply scale bit selects 5 V or 3.3 V measurement; lockable
// - status bit 0 mid rail, bit 2 supply limit violations
// - status bits 4,5,6 remote1, local, remote2 temperature violations
// - status read clears only flags whose condition has gone
// - status bits 1,3 and config bit 4 reserved, read-only
// - status bit 7 is OR of second status register flags
// - high violation when reading above high; low when at or below
// - temperature one degree past a limit sets its flag
module mcsr_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [mcsr_pkg::ADDR_W-1:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [mcsr_pkg::ADDR_W-1:0] araddr,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// measured readings, one byte per channel
	input wire logic [7:0] mid_rail_reading,
	input wire logic [7:0] supply_reading,
	input wire logic [7:0] remote_one_reading,
	input wire logic [7:0] local_reading,
	input wire logic [7:0] remote_two_reading,
	// flags of the second status register
	input wire logic [7:0] second_status_flags,
	// controls to the monitor datapath
	output logic monitor_go,
	output logic fans_max_override,
	output logic spinup_fixed_time,
	output logic bus_timeout_off,
	output logic supply_scale_5v,
	output logic monitor_ready,
	output logic config_locked,
	output logic [8*mcsr_pkg::NUM_LIM-1:0] active_limits,
	// interrupt
	output logic irq
);

	mcsr_pkg::mcsr_state_t s_q;
	mcsr_pkg::mcsr_state_t s_d;
	logic [mcsr_pkg::NUM_CH-1:0] viol;
	logic [7:0] reading [mcsr_pkg::NUM_CH];
	logic [7:0] cond;
	logic [7:0] status_view;
	// one decode flag per register target, read and write side
	logic [mcsr_pkg::ADDR_W-1:0] rd_off;
	logic [mcsr_pkg::ADDR_W-1:0] wr_off;
	logic rd_cfg;
	logic rd_status;
	logic rd_irq_st;
	logic rd_irq_mask;
	logic rd_limit;
	logic wr_cfg;
	logic wr_status;
	logic wr_irq_st;
	logic wr_irq_mask;
	logic wr_limit;
	logic [2:0] rd_ch;
	logic [2:0] wr_ch;
	logic rd_high;
	logic wr_high;

	assign reading[0] = mid_rail_reading;
	assign reading[1] = supply_reading;
	assign reading[2] = remote_one_reading;
	assign reading[3] = local_reading;
	assign reading[4] = remote_two_reading;

	// temperatures are two's complement, voltages unsigned
	genvar g;
	generate
		for (g = 0; g < mcsr_pkg::NUM_CH; g++)
		begin : g_ch
			logic [7:0] lo;
			logic [7:0] hi;
			logic is_temp;
			assign is_temp = (g >= 2);
			// default limits while go is clear, stored ones kept
			assign lo = s_q.cfg[mcsr_pkg::CFG_GO] ? s_q.lim[g].low
				: (is_temp ? mcsr_pkg::TEMP_LOW_DEF : mcsr_pkg::VOLT_LOW_DEF);
			assign hi = s_q.cfg[mcsr_pkg::CFG_GO] ? s_q.lim[g].high
				: (is_temp ? mcsr_pkg::TEMP_HIGH_DEF
				: mcsr_pkg::VOLT_HIGH_DEF);
			assign active_limits[16*g +: 16] = {hi, lo};
			// strict above high, at or below low
			assign viol[g] = is_temp
				? (($signed(reading[g]) > $signed(hi))
				|| ($signed(reading[g]) <= $signed(lo)))
				: ((reading[g] > hi) || (reading[g] <= lo));
		end
	endgenerate

	always_comb
	begin
		cond = 8'h00;
		cond[mcsr_pkg::ST_MID_RAIL] = viol[0];
		cond[mcsr_pkg::ST_SUPPLY] = viol[1];
		cond[mcsr_pkg::ST_REMOTE_ONE] = viol[2];
		cond[mcsr_pkg::ST_LOCAL] = viol[3];
		cond[mcsr_pkg::ST_REMOTE_TWO] = viol[4];
	end

	// bit 7 is live, reserved bits stay zero
	assign status_view = (s_q.status & mcsr_pkg::ST_LATCH_MASK)
		| {|second_status_flags, 7'h00};

	// read address decode straight from the bus, taken in the same cycle
	always_comb
	begin
		rd_cfg = 1'b0;
		rd_status = 1'b0;
		rd_irq_st = 1'b0;
		rd_irq_mask = 1'b0;
		rd_limit = 1'b0;
		rd_off = araddr - mcsr_pkg::ADDR_LIMIT_BASE;
		rd_ch = 3'(rd_off >> mcsr_pkg::LIM_CH_SHIFT);
		rd_high = rd_off[mcsr_pkg::LIM_HIGH_BIT];
		if (araddr == mcsr_pkg::ADDR_SYS_CONFIG)
		begin
			rd_cfg = 1'b1;
		end
		else if (araddr == mcsr_pkg::ADDR_LIMIT_STATUS)
		begin
			rd_status = 1'b1;
		end
		else if (araddr == mcsr_pkg::ADDR_IRQ_STATUS)
		begin
			rd_irq_st = 1'b1;
		end
		else if (araddr == mcsr_pkg::ADDR_IRQ_MASK)
		begin
			rd_irq_mask = 1'b1;
		end
		else if (araddr >= mcsr_pkg::ADDR_LIMIT_BASE
			&& rd_off < mcsr_pkg::LIMIT_SPAN && araddr[1:0] == 2'b00)
		begin
			rd_limit = 1'b1;
		end
	end

	// write decode works on the held address, so aw and w may come apart
	always_comb
	begin
		wr_cfg = 1'b0;
		wr_status = 1'b0;
		wr_irq_st = 1'b0;
		wr_irq_mask = 1'b0;
		wr_limit = 1'b0;
		wr_off = s_q.aw_addr - mcsr_pkg::ADDR_LIMIT_BASE;
		wr_ch = 3'(wr_off >> mcsr_pkg::LIM_CH_SHIFT);
		wr_high = wr_off[mcsr_pkg::LIM_HIGH_BIT];
		if (s_q.aw_addr == mcsr_pkg::ADDR_SYS_CONFIG)
		begin
			wr_cfg = 1'b1;
		end
		else if (s_q.aw_addr == mcsr_pkg::ADDR_LIMIT_STATUS)
		begin
			wr_status = 1'b1;
		end
		else if (s_q.aw_addr == mcsr_pkg::ADDR_IRQ_STATUS)
		begin
			wr_irq_st = 1'b1;
		end
		else if (s_q.aw_addr == mcsr_pkg::ADDR_IRQ_MASK)
		begin
			wr_irq_mask = 1'b1;
		end
		else if (s_q.aw_addr >= mcsr_pkg::ADDR_LIMIT_BASE
			&& wr_off < mcsr_pkg::LIMIT_SPAN && s_q.aw_addr[1:0] == 2'b00)
		begin
			wr_limit = 1'b1;
		end
	end

	always_comb
	begin
		logic [7:0] wbyte;
		logic [7:0] wmask;
		logic [7:0] rd;
		logic do_write;
		logic do_read;
		logic bad;
		logic [7:0] new_ev;
		wbyte = 8'h00;
		wmask = 8'h00;
		rd = 8'h00;
		do_write = 1'b0;
		do_read = 1'b0;
		bad = 1'b0;
		new_ev = 8'h00;
		s_d = s_q;

		// power-up counter, ready once it saturates
		if (s_q.pwr_cnt != 5'(mcsr_pkg::POWERUP_CYCLES))
			s_d.pwr_cnt = s_q.pwr_cnt + 5'd1;
		else
			s_d.cfg[mcsr_pkg::CFG_READY] = 1'b1;

		if (awvalid && !s_q.aw_seen)
		begin
			s_d.aw_seen = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (wvalid && !s_q.w_seen)
		begin
			s_d.w_seen = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end
		if (bvalid && bready)
			s_d.bvalid = 1'b0;
		if (rvalid && rready)
			s_d.rvalid = 1'b0;

		// latch new violations; read clear below cannot drop them
		new_ev = cond & ~s_q.status;
		s_d.status = s_q.status | cond;
		s_d.irq_status = s_q.irq_status | new_ev;

		// read channel
		if (arvalid && !s_q.rvalid)
		begin
			do_read = 1'b1;
			if (rd_cfg)
			begin
				rd = s_q.cfg & ~mcsr_pkg::CFG_RSVD_MASK;
			end
			else if (rd_status)
			begin
				rd = status_view;
				// clear only subsided flags; persisting ones stay
				s_d.status = (s_q.status & cond) | cond;
			end
			else if (rd_irq_st)
			begin
				rd = s_q.irq_status;
			end
			else if (rd_irq_mask)
			begin
				rd = s_q.irq_mask;
			end
			else if (rd_limit)
			begin
				rd = rd_high ? s_q.lim[rd_ch].high : s_q.lim[rd_ch].low;
			end
			else
			begin
				bad = 1'b1;
			end
			s_d.rvalid = 1'b1;
			s_d.rdata = {24'h00_0000, rd};
			s_d.rresp = bad ? mcsr_pkg::RESP_SLVERR : mcsr_pkg::RESP_OKAY;
		end

		// write once both halves are held and the response slot is free
		if (s_q.aw_seen && s_q.w_seen && !s_q.bvalid)
		begin
			do_write = s_q.w_strb[0];
			wbyte = s_q.w_data[7:0];
			bad = 1'b0;
			s_d.aw_seen = 1'b0;
			s_d.w_seen = 1'b0;
			if (wr_cfg)
			begin
				// writable bits minus frozen ones once locked
				wmask = mcsr_pkg::CFG_WR_MASK
					& ~(s_q.cfg[mcsr_pkg::CFG_LOCK]
					? mcsr_pkg::CFG_LOCKABLE : 8'h00);
				if (do_write)
					s_d.cfg = (s_d.cfg & ~wmask) | (wbyte & wmask);
			end
			else if (wr_status)
			begin
				wmask = 8'h00;
			end
			else if (wr_irq_st)
			begin
				// set wins over write-one-to-clear
				if (do_write)
					s_d.irq_status = (s_q.irq_status & ~wbyte) | new_ev;
			end
			else if (wr_irq_mask)
			begin
				if (do_write)
					s_d.irq_mask = wbyte;
			end
			else if (wr_limit)
			begin
				// limits are not lockable, go does not touch them
				if (do_write && wr_high)
				begin
					s_d.lim[wr_ch].high = wbyte;
				end
				else if (do_write)
				begin
					s_d.lim[wr_ch].low = wbyte;
				end
			end
			else
			begin
				bad = 1'b1;
			end
			s_d.bvalid = 1'b1;
			s_d.bresp = bad ? mcsr_pkg::RESP_SLVERR : mcsr_pkg::RESP_OKAY;
		end

		if (!rst_n)
		begin
			s_d = '0;
			s_d.cfg = mcsr_pkg::CFG_RESET;
			s_d.status = mcsr_pkg::STATUS_RESET;
			for (int i = 0; i < mcsr_pkg::NUM_CH; i++)
			begin
				s_d.lim[i].low = (i >= 2) ? mcsr_pkg::TEMP_LOW_DEF
					: mcsr_pkg::VOLT_LOW_DEF;
				s_d.lim[i].high = (i >= 2) ? mcsr_pkg::TEMP_HIGH_DEF
					: mcsr_pkg::VOLT_HIGH_DEF;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		s_q <= s_d;
	end

	assign awready = !s_q.aw_seen;
	assign wready = !s_q.w_seen;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = !s_q.rvalid;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;

	assign monitor_go = s_q.cfg[mcsr_pkg::CFG_GO];
	assign fans_max_override = s_q.cfg[mcsr_pkg::CFG_FANS_MAX];
	assign spinup_fixed_time = s_q.cfg[mcsr_pkg::CFG_SPINUP];
	assign bus_timeout_off = s_q.cfg[mcsr_pkg::CFG_TIMEOUT_OFF];
	assign supply_scale_5v = s_q.cfg[mcsr_pkg::CFG_SUPPLY_5V];
	assign monitor_ready = s_q.cfg[mcsr_pkg::CFG_READY];
	assign config_locked = s_q.cfg[mcsr_pkg::CFG_LOCK];
	assign irq = |(s_q.irq_status & s_q.irq_mask);

endmodule : mcsr_regs

// ===== bench/mcsr_regs_assertions.sv
`timescale 1ns/100ps
module mcsr_regs_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	// configuration outputs
	input wire logic monitor_go,
	input wire logic monitor_ready,
	input wire logic config_locked,
	input wire logic [8*mcsr_pkg::NUM_LIM-1:0] active_limits
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [4:0] up_q;
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			up_q <= 5'h0;
		else if (up_q != 5'h1f)
			up_q <= up_q + 5'h1;
	end
	sequence wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_taken;
		arvalid && arready;
	endsequence
	chk_write_answer: assert property (wr_taken |-> ##2 bvalid)
		else $error("write not answered in two cycles");
	chk_read_answer: assert property (rd_taken |=> rvalid)
		else $error("read not answered next cycle");
	chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	chk_lock_sticky: assert property (config_locked |=> config_locked)
		else $error("lock cleared without reset");
	chk_go_frozen: assert property (config_locked |=> $stable(monitor_go))
		else $error("go changed while locked");
	chk_ready_sticky: assert property (monitor_ready |=> monitor_ready)
		else $error("ready dropped");
	chk_ready_early: assert property (up_q < 5'h10 |-> !monitor_ready)
		else $error("ready before power-up done");
	chk_limit_default: assert property (!monitor_go |->
		active_limits == 80'h7f81_7f81_7f81_ff00_ff00)
		else $error("defaults not used while stopped");
endmodule : mcsr_regs_chk
bind mcsr_regs mcsr_regs_chk u_chk (.*);

// ===== bench/mcsr_sensor_model.sv
`timescale 1ns/100ps
module mcsr_sensor_model (
	// clock
	input wire logic core_clk,
	// readings and second status flags
	output logic [7:0] mid_rail_reading,
	output logic [7:0] supply_reading,
	output logic [7:0] remote_one_reading,
	output logic [7:0] local_reading,
	output logic [7:0] remote_two_reading,
	output logic [7:0] second_status_flags
);
	logic [5:0][7:0] r_q;
	// in-range values until a test moves them
	initial r_q = 48'h0000_2000_8080;
	assign {second_status_flags, remote_two_reading, local_reading} = r_q[5:3];
	assign {remote_one_reading, supply_reading, mid_rail_reading} = r_q[2:0];
	// changes land just after an edge, as a real sampler would
	task automatic set(input int ch, input logic [7:0] v);
		@(posedge core_clk);
		r_q[ch] <= v;
	endtask : set
endmodule : mcsr_sensor_model

// ===== bench/mcsr_regs_tb_top.sv
`timescale 1ns/100ps
module mcsr_regs_tb_top;
	logic core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, monitor_go, monitor_ready;
	logic fans_max_override, spinup_fixed_time, bus_timeout_off;
	logic supply_scale_5v, config_locked;
	logic [9:0] awaddr, araddr;
	logic [7:0] mid_rail_reading, supply_reading;
	logic [7:0] remote_one_reading, local_reading, remote_two_reading;
	logic [7:0] second_status_flags;
	logic [31:0] wdata, rdata, q;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [79:0] active_limits;
	logic [5:0][7:0] v = 48'h0181_2081_0000;
	int miscompares = 0;
	int num_checks = 0;
	mcsr_regs dut (.*);
	mcsr_sensor_model u_sens (.*);
	initial
	begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		#1;
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		logic ta, tw, tr, dn;
		dn = 0;
		@(posedge core_clk);
		if (w)
		begin
			{awvalid, wvalid, bready} <= 3'h7;
			awaddr <= a;
			wdata <= {24'h00_0000, d};
		end
		else
		begin
			{arvalid, rready} <= 2'h3;
			araddr <= a;
		end
		while (!dn)
		begin
			@(negedge core_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tr = arvalid && arready;
			dn = w ? bvalid : rvalid;
			q = rdata;
			rs = w ? bresp : rresp;
			@(posedge core_clk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			if (tr) arvalid <= 0;
			if (dn) {bready, rready} <= 2'h0;
		end
	endtask : bus
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		bus(0, a, 8'h00);
		chk(q, {24'h00_0000, e});
	endtask : rd
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1, a, d);
	endtask : wr
	task automatic sense(input int ch, input logic [7:0] x);
		u_sens.set(ch, x);
		repeat (2) @(posedge core_clk);
	endtask : sense
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (3000) @(posedge core_clk);
		miscompares++;
		summarize();
	end
	initial
	begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 54'h00_0000_0000_000f;
		repeat (10) @(posedge core_clk);
		rst_n <= 1;
		rd(10'h100, 8'h00);
		rd(10'h104, 8'h00);
		wr(10'h218, 8'h10);
		wr(10'h21c, 8'h30);
		wr(10'h184, 8'h20);
		repeat (20) @(posedge core_clk);
		wr(10'h100, 8'hf9);
		rd(10'h100, 8'hed);
		chk(32'({monitor_go, fans_max_override, spinup_fixed_time,
			bus_timeout_off, supply_scale_5v}), 32'h0000_001f);
		sense(3, 8'h31);
		chk(32'(irq), 32'h0000_0001);
		rd(10'h104, 8'h20);
		sense(3, 8'h30);
		rd(10'h104, 8'h20);
		rd(10'h104, 8'h00);
		sense(3, 8'h10);
		rd(10'h104, 8'h20);
		wr(10'h104, 8'hff);
		rd(10'h104, 8'h20);
		wr(10'h180, 8'h20);
		chk(32'(irq), 32'h0000_0000);
		for (int i = 0; i < 6; i++)
			sense(i, v[i]);
		rd(10'h104, 8'hf5);
		chk(32'(irq), 32'h0000_0000);
		wr(10'h100, 8'he8);
		chk(32'(active_limits[63:48]), 32'h0000_7f81);
		wr(10'h100, 8'he9);
		chk(32'(active_limits[63:48]), 32'h0000_3010);
		wr(10'h100, 8'h03);
		wr(10'h100, 8'h08);
		rd(10'h100, 8'h0f);
		bus(0, 10'h020, 8'h00);
		chk(32'(rs), 32'(mcsr_pkg::RESP_SLVERR));
		@(posedge core_clk);
		rst_n <= 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1;
		rd(10'h100, 8'h00);
		summarize();
	end
endmodule : mcsr_regs_tb_top
